// ---- rgu_top.v ----
// Reset generation unit: AXI4-Lite registers, reset requests and escalation
//
// Summary of operation
// - Count functional resets between threshold register writes
// - Count at threshold turns functional into destructive
// - Clear count on software, destructive, power-on
// - Destructive counter starts disabled, nonzero threshold enables
// - Functional counter enabled from reset by default
// - Mode code all zeros requests functional reset
// - Mode code all ones requests destructive reset
// - Event with clear disable bit starts reset
// - Disabled event raises its alternative reaction instead
//
// Local design decisions: the register offsets and the AXI4-Lite register port.
`include "rgu_defs.vh"
`default_nettype none

module rgu_top
(
    input  wire                   aclk,
    input  wire                   aresetn,
    input  wire [`RGU_ADDR_W-1:0] s_axi_awaddr,
    input  wire [2:0]             s_axi_awprot,
    input  wire                   s_axi_awvalid,
    output wire                   s_axi_awready,
    input  wire [31:0]            s_axi_wdata,
    input  wire [3:0]             s_axi_wstrb,
    input  wire                   s_axi_wvalid,
    output wire                   s_axi_wready,
    output reg  [1:0]             s_axi_bresp,
    output reg                    s_axi_bvalid,
    input  wire                   s_axi_bready,
    input  wire [`RGU_ADDR_W-1:0] s_axi_araddr,
    input  wire [2:0]             s_axi_arprot,
    input  wire                   s_axi_arvalid,
    output wire                   s_axi_arready,
    output reg  [31:0]            s_axi_rdata,
    output reg  [1:0]             s_axi_rresp,
    output reg                    s_axi_rvalid,
    input  wire                   s_axi_rready,
    input  wire [`RGU_EVT_N-1:0]  crit_event,
    output reg                    func_reset_req,
    output reg                    dest_reset_req,
    output reg                    reset_hold,
    output reg  [`RGU_EVT_N-1:0]  alt_irq_req,
    output reg  [`RGU_EVT_N-1:0]  alt_safe_req,
    output reg  [`RGU_MODE_W-1:0] mode_target,
    output reg                    mode_change_req
);

    ////////////////////////////////////////////////////////////////////////
    // Register state

    reg  [`RGU_CNT_W-1:0]  functional_escalation_threshold;
    reg  [`RGU_CNT_W-1:0]  destructive_escalation_threshold;
    reg  [`RGU_EVT_N-1:0]  functional_event_reset_disable;
    reg  [`RGU_EVT_N-1:0]  functional_event_alternative_request;
    reg  [`RGU_MODE_W-1:0] mode_control_register;
    reg                    last_dest;

    reg                    aw_held;
    reg                    w_held;
    reg  [`RGU_ADDR_W-1:0] wr_addr;
    reg  [31:0]            wr_data;
    reg  [3:0]             wr_strb;

    wire [`RGU_CNT_W-1:0]  func_count;
    wire [`RGU_CNT_W-1:0]  dest_count;
    wire                   func_at_limit;
    wire                   dest_at_limit;

    // Address is one of the mapped aligned words
    function mapped;
        input [`RGU_ADDR_W-1:0] a;
        begin
            mapped = (a == `RGU_OFF_FUNC_THR) || (a == `RGU_OFF_DEST_THR) ||
                     (a == `RGU_OFF_EVT_DIS) || (a == `RGU_OFF_EVT_ALT) ||
                     (a == `RGU_OFF_MODE_CTRL) || (a == `RGU_OFF_STATUS);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Write channel

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;

    wire commit   = aw_held && w_held && !s_axi_bvalid;
    wire lane0    = commit && wr_strb[0];
    wire wr_fthr  = lane0 && (wr_addr == `RGU_OFF_FUNC_THR);
    wire wr_dthr  = lane0 && (wr_addr == `RGU_OFF_DEST_THR);
    wire wr_dis   = lane0 && (wr_addr == `RGU_OFF_EVT_DIS);
    wire wr_alt   = lane0 && (wr_addr == `RGU_OFF_EVT_ALT);
    wire wr_mode  = lane0 && (wr_addr == `RGU_OFF_MODE_CTRL);
    wire [`RGU_MODE_W-1:0] wr_mode_val = wr_data[`RGU_MODE_LSB +: `RGU_MODE_W];

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            wr_addr      <= {`RGU_ADDR_W{1'b0}};
            wr_data      <= 32'h00000000;
            wr_strb      <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RGU_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                wr_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held  <= 1'b1;
                wr_data <= s_axi_wdata;
                wr_strb <= s_axi_wstrb;
            end
            if (commit)
            begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= mapped(wr_addr) ? `RGU_RESP_OKAY : `RGU_RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            // Functional threshold nonzero, destructive zero
            functional_escalation_threshold      <= `RGU_FUNC_THR_RST;
            destructive_escalation_threshold     <= `RGU_DEST_THR_RST;
            functional_event_reset_disable       <= `RGU_EVT_DIS_RST;
            functional_event_alternative_request <= `RGU_EVT_ALT_RST;
            mode_control_register                <= `RGU_MODE_RST;
        end
        else
        begin
            if (wr_fthr)
                functional_escalation_threshold <= wr_data[`RGU_CNT_W-1:0];
            if (wr_dthr)
                destructive_escalation_threshold <= wr_data[`RGU_CNT_W-1:0];
            if (wr_dis)
                functional_event_reset_disable <= wr_data[`RGU_EVT_N-1:0];
            if (wr_alt)
                functional_event_alternative_request <= wr_data[`RGU_EVT_N-1:0];
            if (wr_mode)
                mode_control_register <= wr_mode_val;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read channel

    assign s_axi_arready = !s_axi_rvalid;

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `RGU_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= mapped(s_axi_araddr) ? `RGU_RESP_OKAY : `RGU_RESP_SLVERR;
            s_axi_rdata  <= 32'h00000000;
            case (s_axi_araddr)
                `RGU_OFF_FUNC_THR:
                    s_axi_rdata[`RGU_CNT_W-1:0] <= functional_escalation_threshold;
                `RGU_OFF_DEST_THR:
                    s_axi_rdata[`RGU_CNT_W-1:0] <= destructive_escalation_threshold;
                `RGU_OFF_EVT_DIS:
                    s_axi_rdata[`RGU_EVT_N-1:0] <= functional_event_reset_disable;
                `RGU_OFF_EVT_ALT:
                    s_axi_rdata[`RGU_EVT_N-1:0] <= functional_event_alternative_request;
                `RGU_OFF_MODE_CTRL:
                    s_axi_rdata[`RGU_MODE_W-1:0] <= mode_control_register;
                `RGU_OFF_STATUS:
                begin
                    s_axi_rdata[`RGU_STAT_FCNT_LSB +: `RGU_CNT_W] <= func_count;
                    s_axi_rdata[`RGU_STAT_DCNT_LSB +: `RGU_CNT_W] <= dest_count;
                    s_axi_rdata[`RGU_STAT_HOLD_BIT]               <= reset_hold;
                    s_axi_rdata[`RGU_STAT_LAST_BIT]               <= last_dest;
                end
                default:
                    s_axi_rdata <= 32'h00000000;
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset decision

    // Enabled events start a reset, disabled ones take their alternative
    wire [`RGU_EVT_N-1:0] evt_reset = crit_event & ~functional_event_reset_disable;
    wire [`RGU_EVT_N-1:0] evt_alt   = crit_event & functional_event_reset_disable;

    wire sw_func   = wr_mode && (wr_mode_val == `RGU_MODE_FUNC_RESET);
    wire sw_dest   = wr_mode && (wr_mode_val == `RGU_MODE_DEST_RESET);
    wire func_want = sw_func || (|evt_reset);

    // At the threshold a functional request escalates
    wire do_dest   = sw_dest || (func_want && func_at_limit);
    wire do_func   = func_want && !do_dest;

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            func_reset_req  <= 1'b0;
            dest_reset_req  <= 1'b0;
            reset_hold      <= 1'b0;
            last_dest       <= 1'b0;
            alt_irq_req     <= {`RGU_EVT_N{1'b0}};
            alt_safe_req    <= {`RGU_EVT_N{1'b0}};
            mode_target     <= `RGU_MODE_RST;
            mode_change_req <= 1'b0;
        end
        else
        begin
            func_reset_req  <= do_func;
            dest_reset_req  <= do_dest;
            alt_irq_req     <= evt_alt & functional_event_alternative_request;
            alt_safe_req    <= evt_alt & ~functional_event_alternative_request;
            mode_change_req <= wr_mode && !sw_func && !sw_dest;
            if (wr_mode)
                mode_target <= wr_mode_val;
            if (do_dest || do_func)
                last_dest <= do_dest;
            // Destructive escalation holds the chip in reset
            if (do_dest && dest_at_limit)
                reset_hold <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Escalation counters

    // Threshold write clears, functional resets count, destructive clears
    rgu_esc_counter u_func_cnt
    (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .clr      (wr_fthr || do_dest),
        .inc      (do_func),
        .thr      (functional_escalation_threshold),
        .count    (func_count),
        .at_limit (func_at_limit)
    );

    // Destructive resets count only while threshold nonzero
    rgu_esc_counter u_dest_cnt
    (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .clr      (wr_dthr),
        .inc      (do_dest),
        .thr      (destructive_escalation_threshold),
        .count    (dest_count),
        .at_limit (dest_at_limit)
    );

endmodule // rgu_top

`default_nettype wire

// ---- rgu_defs.vh ----
// Constants for the reset generation unit: register map, fields, reset values
`ifndef RGU_DEFS_VH
`define RGU_DEFS_VH

`define RGU_ADDR_W          8
`define RGU_CNT_W           4
`define RGU_EVT_N           8

`define RGU_OFF_FUNC_THR    8'h00
`define RGU_OFF_DEST_THR    8'h04
`define RGU_OFF_EVT_DIS     8'h08
`define RGU_OFF_EVT_ALT     8'h0c
`define RGU_OFF_MODE_CTRL   8'h10
`define RGU_OFF_STATUS      8'h14

`define RGU_FUNC_THR_RST    4'hf
`define RGU_DEST_THR_RST    4'h0
`define RGU_EVT_DIS_RST     8'h00
`define RGU_EVT_ALT_RST     8'h00
`define RGU_MODE_RST        4'h0

`define RGU_MODE_LSB        0
`define RGU_MODE_W          4
`define RGU_MODE_FUNC_RESET 4'h0
`define RGU_MODE_DEST_RESET 4'hf

`define RGU_STAT_FCNT_LSB   0
`define RGU_STAT_DCNT_LSB   4
`define RGU_STAT_HOLD_BIT   8
`define RGU_STAT_LAST_BIT   9

`define RGU_RESP_OKAY       2'b00
`define RGU_RESP_SLVERR     2'b10

`endif

// ---- rgu_esc_counter.v ----
// Escalation counter with threshold compare and enable by non-zero threshold
`include "rgu_defs.vh"
`default_nettype none

module rgu_esc_counter
(
    input  wire                   aclk,
    input  wire                   aresetn,
    input  wire                   clr,
    input  wire                   inc,
    input  wire [`RGU_CNT_W-1:0]  thr,
    output reg  [`RGU_CNT_W-1:0]  count,
    output wire                   at_limit
);

    // Zero threshold keeps the counter out of play
    assign at_limit = (thr != {`RGU_CNT_W{1'b0}}) && (count == thr);

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            count <= {`RGU_CNT_W{1'b0}};
        end
        else if (inc && (thr != {`RGU_CNT_W{1'b0}}) && (count != thr))
        begin
            // A clear and an increment in the same cycle leave the count at one
            count <= clr ? {{(`RGU_CNT_W-1){1'b0}}, 1'b1} : count + 1'b1;
        end
        else if (clr)
        begin
            count <= {`RGU_CNT_W{1'b0}};
        end
    end

endmodule // rgu_esc_counter

`default_nettype wire

// ---- rgu_top_sva.sv ----
// Checker for the reset generation unit ports
`include "rgu_defs.vh"
`default_nettype none
module rgu_top_chk
(
    input wire logic                  aclk,
    input wire logic                  aresetn,
    input wire logic                  s_axi_awvalid,
    input wire logic                  s_axi_awready,
    input wire logic                  s_axi_wvalid,
    input wire logic                  s_axi_wready,
    input wire logic                  s_axi_bvalid,
    input wire logic                  s_axi_arvalid,
    input wire logic                  s_axi_arready,
    input wire logic                  s_axi_rvalid,
    input wire logic [`RGU_EVT_N-1:0] crit_event,
    input wire logic                  func_reset_req,
    input wire logic                  dest_reset_req,
    input wire logic                  reset_hold,
    input wire logic [`RGU_EVT_N-1:0] alt_irq_req,
    input wire logic [`RGU_EVT_N-1:0] alt_safe_req
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////////////
    sequence s_both_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_commit;
        !s_axi_bvalid ##1 s_axi_bvalid;
    endsequence
    a_write_answer:
        assert property (s_both_taken |=> s_commit) else $error("write answer late");
    a_read_answer:
        assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read");
    a_write_busy:
        assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("aw busy");
    a_read_busy:
        assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar busy");
    a_dest_first:
        assert property (!(func_reset_req && dest_reset_req)) else $error("both resets");
    a_func_cause:
        assert property (func_reset_req |-> $past(crit_event) != 0 || $rose(s_axi_bvalid))
        else $error("func reset uncaused");
    a_dest_cause:
        assert property (dest_reset_req |-> $past(crit_event) != 0 || $rose(s_axi_bvalid))
        else $error("dest reset uncaused");
    a_alt_cause:
        assert property ((alt_irq_req | alt_safe_req) != 0 |->
            ((alt_irq_req | alt_safe_req) & ~$past(crit_event)) == 0 &&
            (alt_irq_req & alt_safe_req) == 0) else $error("alt request uncaused");
    a_hold_sticky:
        assert property (reset_hold |=> reset_hold) else $error("hold dropped");
    a_reset_quiet:
        assert property (disable iff (1'b0) !aresetn |=> !func_reset_req && !dest_reset_req
            && !reset_hold) else $error("reset outputs active");
endmodule // rgu_top_chk
bind rgu_top rgu_top_chk u_chk
(
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .crit_event(crit_event), .func_reset_req(func_reset_req),
    .dest_reset_req(dest_reset_req), .reset_hold(reset_hold), .alt_irq_req(alt_irq_req),
    .alt_safe_req(alt_safe_req)
);
`default_nettype wire

// ---- rgu_event_src.sv ----
// Model of the critical event sources
`include "rgu_defs.vh"
`default_nettype none
module rgu_event_src
(
    input  wire logic                  aclk,
    output var  logic [`RGU_EVT_N-1:0] crit_event
);
    timeunit 1ns;
    timeprecision 1ns;
    initial crit_event = '0;
    // One-cycle event pulse
    task automatic fire(input logic [`RGU_EVT_N-1:0] m);
        crit_event <= m;
        @(posedge aclk);
        crit_event <= '0;
    endtask
endmodule // rgu_event_src
`default_nettype wire

// ---- testbench.sv ----
// Self-checking testbench for the reset generation unit
`include "rgu_defs.vh"
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic                   aclk, aresetn, awvalid, awready, wvalid, wready, bvalid;
    logic                   arvalid, arready, rvalid, func_req, dest_req, hold, chg;
    logic [`RGU_ADDR_W-1:0] awaddr, araddr;
    logic [31:0]            wdata, rdata, d;
    logic [1:0]             bresp, rresp, r;
    logic [`RGU_EVT_N-1:0]  crit, alt_irq, alt_safe;
    logic [`RGU_MODE_W-1:0] target;
    logic [3:0]             codes [3] = '{4'h0, 4'hf, 4'h5};
    int                     miscompares = 0;
    int                     compares = 0;
    rgu_top u_rgu_top
    (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .crit_event(crit),
        .func_reset_req(func_req), .dest_reset_req(dest_req), .reset_hold(hold),
        .alt_irq_req(alt_irq), .alt_safe_req(alt_safe), .mode_target(target),
        .mode_change_req(chg)
    );
    rgu_event_src u_src (.aclk(aclk), .crit_event(crit));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end
        while (!bvalid && n < 100);
        r = bresp;
        if (n >= 100) miscompares++;
    endtask
    task automatic rd(input logic [7:0] a);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (arready) arvalid <= 1'b0;
        end
        while (!rvalid && n < 100);
        d = rdata;
        r = rresp;
        if (n >= 100) miscompares++;
    endtask
    task automatic event_check(input logic [7:0] m, input logic [31:0] exp);
        u_src.fire(m);
        @(posedge aclk);
        chk({func_req, dest_req, alt_irq, alt_safe}, exp);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    initial
    begin
        repeat (5000) @(posedge aclk);
        miscompares++;
        wrap_up;
    end
    initial
    begin
        aresetn = 1'b0;
        {awaddr, araddr, wdata, awvalid, wvalid, arvalid} = '0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int i = 0; i < 6; i++)
        begin
            rd(8'(4 * i));
            chk(d, (i == 0) ? 32'(`RGU_FUNC_THR_RST) : 32'h0);
        end
        rd(8'h18);
        chk(d, 32'h0);
        chk(r, `RGU_RESP_SLVERR);
        wr(8'h1c, 32'h1);
        chk(r, `RGU_RESP_SLVERR);
        event_check(8'h01, {2'b10, 16'h0});
        rd(`RGU_OFF_STATUS);
        chk(d[3:0], 4'h1);
        wr(`RGU_OFF_FUNC_THR, 32'h2);
        rd(`RGU_OFF_STATUS);
        chk(d[3:0], 4'h0);
        for (int i = 0; i < 3; i++)
            event_check(8'h01, (i < 2) ? {2'b10, 16'h0} : {2'b01, 16'h0});
        rd(`RGU_OFF_STATUS);
        chk({hold, d[3:0]}, 5'h0);
        wr(`RGU_OFF_FUNC_THR, 32'h0);
        for (int i = 0; i < 17; i++)
            event_check(8'h01, {2'b10, 16'h0});
        wr(`RGU_OFF_EVT_DIS, 32'h03);
        wr(`RGU_OFF_EVT_ALT, 32'h01);
        event_check(8'h07, {2'b10, 8'h01, 8'h02});
        for (int i = 0; i < 3; i++)
        begin
            wr(`RGU_OFF_MODE_CTRL, 32'(codes[i]));
            chk({func_req, dest_req, chg}, {codes[i] == 4'h0, codes[i] == 4'hf, i == 2});
            chk(target, codes[i]);
        end
        wr(`RGU_OFF_DEST_THR, 32'h1);
        wr(`RGU_OFF_MODE_CTRL, 32'hf);
        chk({dest_req, hold}, 2'b10);
        wr(`RGU_OFF_MODE_CTRL, 32'hf);
        chk(hold, 1'b1);
        rd(`RGU_OFF_STATUS);
        chk(d, 32'h310);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(`RGU_OFF_STATUS);
        chk(d, 32'h0);
        chk(hold, 1'b0);
        rd(`RGU_OFF_FUNC_THR);
        chk(d, 32'(`RGU_FUNC_THR_RST));
        wrap_up;
    end
endmodule // testbench
`default_nettype wire
